// file: asf_consts.svh
// Constants of the converter control and sound-file store block.
// Assumes inclusion by asf_ctrl.sv only; asf_pkg.sv does not include it.
// Contract
// - Control register resets to 128, inhibited
// - Write with inhibit clear starts conversions
// - Continuous sample rate is baud over ten
// - Setting inhibit halts conversions at once
// - One-shot end sets inhibit bit again
// - Trigger source one waits for falling edge
// - Trigger source zero starts without waiting
// - Continuous repeats channel or sweeps endlessly
// - Clearing continuous bit stops running converter
// - Sweep bit picks scan versus single channel
// - Gain bit routes through gain output pin
// - One-shot on a single channel sends one sample or records sixteen; one-shot scan does one sweep
// - File index counts from zero by order
// - Labels 0..65534 accepted; label zero never matches
// - Label-select bit governs play and erase
// - Play starts file by index or label
// - Commands handled strictly in arrival order
// - Volume five plays at original level
// - File results report codes zero to fifteen, never eleven
// - Erase holds busy, sends four, then six
// - Result is one clamped 8-bit value
`ifndef ASF_CONSTS_SVH
`define ASF_CONSTS_SVH

`define ASF_CTRL_RESET       8'h80
`define ASF_BIT_HOLD         7
`define ASF_BIT_GAIN         6
`define ASF_BIT_TRIG         5
`define ASF_BIT_REPEAT       4
`define ASF_BIT_SCAN         3
`define ASF_BIT_RSVD         2
`define ASF_CTRL_WR_MASK     8'hFB
`define ASF_GAIN_CHANNEL     3'h4
`define ASF_BAUDS_PER_SAMPLE 10
`define ASF_REC_ONESHOT_CNT  5'h10
`define ASF_VOL_UNITY        4'h5
`define ASF_VOL_MAX          4'h9
`define ASF_LABEL_NONE       16'h0000
`define ASF_LABEL_MAX        16'hFFFE

`define ASF_RC_OK            4'h0
`define ASF_RC_BAD_CMD       4'h1
`define ASF_RC_COMM          4'h2
`define ASF_RC_TIMEOUT       4'h3
`define ASF_RC_ERASE_BUSY    4'h4
`define ASF_RC_ERASE_DONE    4'h6
`define ASF_RC_NO_MEM        4'h8
`define ASF_RC_DUP_LABEL     4'hD
`define ASF_RC_NOT_FOUND     4'hE
`define ASF_RC_REC_BUSY      4'hF

`endif

// file: asf_pkg.sv
// Shared types of the converter control and sound-file store block.
// Assumes the constants header is compiled alongside.
package asf_pkg;

    typedef enum logic [2:0]
    {
        ASF_OP_WR_CTRL,
        ASF_OP_PLAY,
        ASF_OP_ERASE,
        ASF_OP_LABEL_MODE,
        ASF_OP_VOLUME,
        ASF_OP_ADD_FILE
    } asf_op_t;

    typedef enum logic [1:0]
    {
        ASF_CV_IDLE,
        ASF_CV_ARMED,
        ASF_CV_RUN
    } asf_conv_t;

    typedef enum logic [1:0]
    {
        ASF_FS_IDLE,
        ASF_FS_SHIFT,
        ASF_FS_DONE
    } asf_fs_t;

endpackage : asf_pkg

// file: asf_ctrl.sv
// Converter sequencing, result transmit and sound-file index store.
// Assumes commands are already parsed from the host stream into op and
// argument, and that the converter result for the selected input is
// presented on I_ADC_RESULT, already limited to 0..255.
`timescale 1ns/1ps
`include "asf_consts.svh"

module asf_ctrl
#(
    parameter int CLKS_PER_BAUD = 868,
    parameter int MAX_FILES     = 16,
    parameter int IDX_W         = 4
)
(
    input  wire logic              I_CLOCK,
    input  wire logic              I_ARST_N,
    input  wire logic              I_CMD_VALID,
    input  wire logic [2:0]        I_CMD_OP,
    input  wire logic [15:0]       I_CMD_ARG,
    output logic                   O_CMD_READY,
    input  wire logic              I_EXT_TRIGGER,
    input  wire logic              I_RECORD_ACTIVE,
    input  wire logic [7:0]        I_ADC_RESULT,
    output logic [2:0]             O_ADC_SOURCE,
    output logic                   O_GAIN_ROUTE,
    output logic [7:0]             O_CTRL_VALUE,
    output logic                   O_TX_VALID,
    output logic [7:0]             O_TX_DATA,
    output logic                   O_REC_VALID,
    output logic [7:0]             O_REC_DATA,
    output logic                   O_PLAY_START,
    output logic [IDX_W-1:0]       O_PLAY_INDEX,
    output logic [3:0]             O_PLAY_VOLUME,
    output logic                   O_CLEAR_TO_SEND_N,
    output logic [IDX_W:0]         O_FILE_COUNT
);

    localparam int SAMPLE_CLKS = CLKS_PER_BAUD * `ASF_BAUDS_PER_SAMPLE;
    localparam int TICK_W      = $clog2(SAMPLE_CLKS + 1);

    typedef struct packed
    {
        logic [7:0]                  ctrl;
        asf_pkg::asf_conv_t          conv;
        logic [TICK_W-1:0]           tick;
        logic [1:0]                  chan;
        logic [4:0]                  left;
        logic [2:0]                  trig_sync;
        logic                        sample_pend;
        logic [7:0]                  sample_val;
        logic                        code_pend;
        logic [3:0]                  code_val;
        logic                        tx_valid;
        logic [7:0]                  tx_data;
        logic                        rec_valid;
        logic [7:0]                  rec_data;
        logic                        by_label;
        logic [3:0]                  volume;
        logic                        play_start;
        logic [IDX_W-1:0]            play_index;
        logic [MAX_FILES-1:0][15:0]  labels;
        logic [IDX_W:0]              count;
        asf_pkg::asf_fs_t            fs;
        logic [IDX_W:0]              pos;
        logic                        busy_n;
        logic [2:0]                  src;
        logic                        cts_n;
    } asf_state_t;

    asf_state_t st_reg;
    asf_state_t st_next;

    // Finds a file by index or by label; label zero never hits
    function automatic logic [IDX_W:0] asf_find
    (
        input logic [MAX_FILES-1:0][15:0] labels,
        input logic [IDX_W:0]             count,
        input logic [15:0]                key,
        input logic                       by_label
    );
        logic [IDX_W:0] hit;
        hit = {1'b1, {IDX_W{1'b0}}};
        if (!by_label)
        begin
            if (key < 16'(count))
            begin
                hit = {1'b0, key[IDX_W-1:0]};
            end
        end
        else if (key != `ASF_LABEL_NONE)
        begin
            for (int i = MAX_FILES - 1; i >= 0; i--)
            begin
                if ((i < int'(count)) && (labels[i] == key))
                begin
                    hit = {1'b0, IDX_W'(i)};
                end
            end
        end
        return hit;
    endfunction : asf_find

    // Returns a result code; reserved code eleven is replaced
    function automatic logic [3:0] asf_code
    (
        input logic [3:0] code
    );
        return (code == 4'hB) ? `ASF_RC_BAD_CMD : code;
    endfunction : asf_code

    always_comb
    begin
        logic            start;
        logic            fall;
        logic            sample_now;
        logic [IDX_W:0]  found;
        logic [7:0]      wr_val;
        st_next                = st_reg;
        start                  = 1'b0;
        found                  = {1'b1, {IDX_W{1'b0}}};
        wr_val                 = I_CMD_ARG[7:0] & `ASF_CTRL_WR_MASK;
        st_next.tx_valid       = 1'b0;
        st_next.rec_valid      = 1'b0;
        st_next.play_start     = 1'b0;
        st_next.trig_sync      = {st_reg.trig_sync[1:0], I_EXT_TRIGGER};
        fall                   = st_reg.trig_sync[2] & ~st_reg.trig_sync[1];

        // Command intake, one at a time in arrival order
        if (I_CMD_VALID && st_reg.busy_n && st_reg.fs == asf_pkg::ASF_FS_IDLE)
        begin
            unique case (I_CMD_OP)
                asf_pkg::ASF_OP_WR_CTRL:
                begin
                    st_next.ctrl = wr_val;
                    if (wr_val[`ASF_BIT_HOLD])
                    begin
                        st_next.conv = asf_pkg::ASF_CV_IDLE;
                        st_next.chan = wr_val[`ASF_BIT_SCAN] ? 2'h0 : wr_val[1:0];
                    end
                    else
                    begin
                        start = 1'b1;
                    end
                end
                asf_pkg::ASF_OP_PLAY:
                begin
                    found = asf_find(st_reg.labels, st_reg.count, I_CMD_ARG,
                                     st_reg.by_label);
                    st_next.code_pend = 1'b1;
                    if (found[IDX_W])
                    begin
                        st_next.code_val = asf_code(`ASF_RC_NOT_FOUND);
                    end
                    else
                    begin
                        st_next.play_start = 1'b1;
                        st_next.play_index = found[IDX_W-1:0];
                        st_next.code_val   = asf_code(`ASF_RC_OK);
                    end
                end
                asf_pkg::ASF_OP_ERASE:
                begin
                    found = asf_find(st_reg.labels, st_reg.count, I_CMD_ARG,
                                     st_reg.by_label);
                    st_next.code_pend = 1'b1;
                    if (found[IDX_W])
                    begin
                        st_next.code_val = asf_code(`ASF_RC_NOT_FOUND);
                    end
                    else
                    begin
                        st_next.code_val = asf_code(`ASF_RC_ERASE_BUSY);
                        st_next.busy_n   = 1'b0;
                        st_next.pos      = found;
                        st_next.fs       = asf_pkg::ASF_FS_SHIFT;
                    end
                end
                asf_pkg::ASF_OP_LABEL_MODE:
                begin
                    st_next.by_label = I_CMD_ARG[0];
                end
                asf_pkg::ASF_OP_VOLUME:
                begin
                    st_next.volume = (I_CMD_ARG[3:0] > `ASF_VOL_MAX) ?
                                     `ASF_VOL_MAX : I_CMD_ARG[3:0];
                end
                asf_pkg::ASF_OP_ADD_FILE:
                begin
                    found = asf_find(st_reg.labels, st_reg.count, I_CMD_ARG, 1'b1);
                    st_next.code_pend = 1'b1;
                    if (st_reg.count == (IDX_W+1)'(MAX_FILES))
                    begin
                        st_next.code_val = asf_code(`ASF_RC_NO_MEM);
                    end
                    else if (!found[IDX_W] || I_CMD_ARG > `ASF_LABEL_MAX)
                    begin
                        st_next.code_val = asf_code(`ASF_RC_DUP_LABEL);
                    end
                    else
                    begin
                        st_next.labels[st_reg.count[IDX_W-1:0]] = I_CMD_ARG;
                        st_next.count    = st_reg.count + 1'b1;
                        st_next.code_val = asf_code(`ASF_RC_OK);
                    end
                end
                default:
                begin
                    st_next.code_pend = 1'b1;
                    st_next.code_val  = asf_code(`ASF_RC_BAD_CMD);
                end
            endcase
        end

        // Erase closes the gap one entry per cycle, then reports done
        unique case (st_reg.fs)
            asf_pkg::ASF_FS_IDLE:
            begin
            end
            asf_pkg::ASF_FS_SHIFT:
            begin
                if (st_reg.pos + 1'b1 >= st_reg.count)
                begin
                    st_next.count = st_reg.count - 1'b1;
                    st_next.fs    = asf_pkg::ASF_FS_DONE;
                end
                else
                begin
                    st_next.labels[st_reg.pos[IDX_W-1:0]] =
                        st_reg.labels[st_reg.pos[IDX_W-1:0] + 1'b1];
                    st_next.pos = st_reg.pos + 1'b1;
                end
            end
            asf_pkg::ASF_FS_DONE:
            begin
                if (!st_reg.code_pend)
                begin
                    st_next.busy_n    = 1'b1;
                    st_next.code_pend = 1'b1;
                    st_next.code_val  = asf_code(`ASF_RC_ERASE_DONE);
                    st_next.fs        = asf_pkg::ASF_FS_IDLE;
                end
            end
        endcase

        // Sample rate divider: ten baud periods per sample
        sample_now = (st_reg.tick == TICK_W'(SAMPLE_CLKS - 1));
        if (st_reg.conv != asf_pkg::ASF_CV_RUN || sample_now)
        begin
            st_next.tick = '0;
        end
        else
        begin
            st_next.tick = st_reg.tick + 1'b1;
        end

        unique case (st_reg.conv)
            asf_pkg::ASF_CV_IDLE:
            begin
            end
            asf_pkg::ASF_CV_ARMED:
            begin
                if (fall)
                begin
                    st_next.conv = asf_pkg::ASF_CV_RUN;
                end
            end
            asf_pkg::ASF_CV_RUN:
            begin
                if (!st_next.ctrl[`ASF_BIT_REPEAT] && st_reg.ctrl[`ASF_BIT_REPEAT])
                begin
                    st_next.conv = asf_pkg::ASF_CV_IDLE;
                    st_next.ctrl[`ASF_BIT_HOLD] = 1'b1;
                end
                else if (sample_now && !start && !st_next.ctrl[`ASF_BIT_HOLD])
                begin
                    if (I_RECORD_ACTIVE)
                    begin
                        st_next.rec_valid = 1'b1;
                        st_next.rec_data  = I_ADC_RESULT;
                    end
                    else
                    begin
                        st_next.sample_pend = 1'b1;
                        st_next.sample_val  = I_ADC_RESULT;
                    end
                    if (st_reg.ctrl[`ASF_BIT_SCAN])
                    begin
                        if (st_reg.chan == st_reg.ctrl[1:0])
                        begin
                            st_next.chan = 2'h0;
                            if (!st_reg.ctrl[`ASF_BIT_REPEAT] && st_reg.left == 5'h1)
                            begin
                                st_next.conv = asf_pkg::ASF_CV_IDLE;
                                st_next.ctrl[`ASF_BIT_HOLD] = 1'b1;
                            end
                            else if (!st_reg.ctrl[`ASF_BIT_REPEAT])
                            begin
                                st_next.left = st_reg.left - 1'b1;
                            end
                        end
                        else
                        begin
                            st_next.chan = st_reg.chan + 1'b1;
                        end
                    end
                    else if (!st_reg.ctrl[`ASF_BIT_REPEAT])
                    begin
                        st_next.left = st_reg.left - 1'b1;
                        if (st_reg.left == 5'h1)
                        begin
                            st_next.conv = asf_pkg::ASF_CV_IDLE;
                            st_next.ctrl[`ASF_BIT_HOLD] = 1'b1;
                        end
                    end
                end
            end
        endcase

        if (start)
        begin
            st_next.tick = '0;
            st_next.chan = wr_val[`ASF_BIT_SCAN] ? 2'h0 : wr_val[1:0];
            st_next.left = (I_RECORD_ACTIVE && !wr_val[`ASF_BIT_SCAN]) ?
                           `ASF_REC_ONESHOT_CNT : 5'h01;
            st_next.conv = wr_val[`ASF_BIT_TRIG] ? asf_pkg::ASF_CV_ARMED
                                                 : asf_pkg::ASF_CV_RUN;
        end

        // Transmit: result codes ahead of converter samples
        if (st_reg.code_pend)
        begin
            st_next.tx_valid  = 1'b1;
            st_next.tx_data   = {4'h0, st_reg.code_val};
            st_next.code_pend = 1'b0;
        end
        else if (st_reg.sample_pend)
        begin
            st_next.tx_valid    = 1'b1;
            st_next.tx_data     = st_reg.sample_val;
            st_next.sample_pend = 1'b0;
        end

        // Output copies kept in flops
        st_next.src   = st_next.ctrl[`ASF_BIT_GAIN] ? `ASF_GAIN_CHANNEL
                                                    : {1'b0, st_next.chan};
        st_next.cts_n = ~st_next.busy_n;
    end

    always_ff @(posedge I_CLOCK or negedge I_ARST_N)
    begin
        if (!I_ARST_N)
        begin
            st_reg        <= '0;
            st_reg.ctrl   <= `ASF_CTRL_RESET;
            st_reg.volume <= `ASF_VOL_UNITY;
            st_reg.busy_n <= 1'b1;
            st_reg.trig_sync <= 3'h7;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    assign O_CMD_READY       = st_reg.busy_n;
    assign O_ADC_SOURCE      = st_reg.src;
    assign O_GAIN_ROUTE      = st_reg.ctrl[`ASF_BIT_GAIN];
    assign O_CTRL_VALUE      = st_reg.ctrl;
    assign O_TX_VALID        = st_reg.tx_valid;
    assign O_TX_DATA         = st_reg.tx_data;
    assign O_REC_VALID       = st_reg.rec_valid;
    assign O_REC_DATA        = st_reg.rec_data;
    assign O_PLAY_START      = st_reg.play_start;
    assign O_PLAY_INDEX      = st_reg.play_index;
    assign O_PLAY_VOLUME     = st_reg.volume;
    assign O_CLEAR_TO_SEND_N = st_reg.cts_n;
    assign O_FILE_COUNT      = st_reg.count;

endmodule : asf_ctrl

// file: asf_checker.sv
// Port-level checks on the converter control and file store block.
// Assumes it is bound into asf_ctrl and sees only that module's ports.
`timescale 1ns/1ps
module asf_checker
(
    input wire logic       I_CLOCK,
    input wire logic       I_ARST_N,
    input wire logic       I_CMD_VALID,
    input wire logic [2:0] I_CMD_OP,
    input wire logic       I_RECORD_ACTIVE,
    input wire logic       O_CMD_READY,
    input wire logic [2:0] O_ADC_SOURCE,
    input wire logic       O_GAIN_ROUTE,
    input wire logic [7:0] O_CTRL_VALUE,
    input wire logic       O_TX_VALID,
    input wire logic [7:0] O_TX_DATA,
    input wire logic       O_REC_VALID,
    input wire logic       O_PLAY_START,
    input wire logic [3:0] O_PLAY_VOLUME,
    input wire logic       O_CLEAR_TO_SEND_N
);
    default clocking cb @(posedge I_CLOCK); endclocking
    default disable iff (!I_ARST_N);
    sequence s_play_take;
        I_CMD_VALID && O_CMD_READY && I_CMD_OP == 3'h1;
    endsequence
    sequence s_busy_code;
        !O_CMD_READY ##1 (O_TX_VALID && O_TX_DATA == 8'h04);
    endsequence
    sequence s_done_code;
        O_CMD_READY ##1 (O_TX_VALID && O_TX_DATA == 8'h06);
    endsequence
    property p_reset_value;
        $rose(I_ARST_N) |-> O_CTRL_VALUE == 8'h80 && O_PLAY_VOLUME == 4'h5;
    endproperty
    property p_gain_source;
        O_CTRL_VALUE[6] && $stable(O_CTRL_VALUE) |-> O_GAIN_ROUTE && O_ADC_SOURCE == 3'h4;
    endproperty
    property p_single_source;
        !O_CTRL_VALUE[6] && !O_CTRL_VALUE[3] && $stable(O_CTRL_VALUE)
            |-> O_ADC_SOURCE == {1'b0, O_CTRL_VALUE[1:0]};
    endproperty
    property p_hold_quiet;
        O_CTRL_VALUE[7] && $past(O_CTRL_VALUE[7]) |-> !O_REC_VALID;
    endproperty
    property p_oneshot_rearm;
        !O_CTRL_VALUE[7] && !O_CTRL_VALUE[4] && !O_CTRL_VALUE[3] && !I_RECORD_ACTIVE
            && O_TX_VALID |-> ##[0:1] O_CTRL_VALUE[7];
    endproperty
    property p_play_answer;
        s_play_take |-> ##2 O_TX_VALID;
    endproperty
    property p_play_ok;
        O_PLAY_START |=> O_TX_VALID && O_TX_DATA == 8'h00;
    endproperty
    property p_erase_busy;
        $rose(O_CLEAR_TO_SEND_N) |-> s_busy_code;
    endproperty
    property p_erase_done;
        $fell(O_CLEAR_TO_SEND_N) |-> s_done_code;
    endproperty
    a_reset_value: assert property (p_reset_value)
        else $error("control or volume wrong after reset");
    a_gain_source: assert property (p_gain_source)
        else $error("gain stage pin not selected");
    a_single_source: assert property (p_single_source)
        else $error("single channel source mismatch");
    a_hold_quiet: assert property (p_hold_quiet)
        else $error("sample stored while held");
    a_oneshot_rearm: assert property (p_oneshot_rearm)
        else $error("one-shot did not set hold again");
    a_play_answer: assert property (p_play_answer)
        else $error("play gave no result code");
    a_play_ok: assert property (p_play_ok)
        else $error("play start not followed by success code");
    a_erase_busy: assert property (p_erase_busy)
        else $error("erase busy code missing");
    a_erase_done: assert property (p_erase_done)
        else $error("erase done code missing");
endmodule : asf_checker

bind asf_ctrl asf_checker chk (.I_CLOCK(I_CLOCK), .I_ARST_N(I_ARST_N),
    .I_CMD_VALID(I_CMD_VALID), .I_CMD_OP(I_CMD_OP), .I_RECORD_ACTIVE(I_RECORD_ACTIVE),
    .O_CMD_READY(O_CMD_READY), .O_ADC_SOURCE(O_ADC_SOURCE), .O_GAIN_ROUTE(O_GAIN_ROUTE),
    .O_CTRL_VALUE(O_CTRL_VALUE), .O_TX_VALID(O_TX_VALID), .O_TX_DATA(O_TX_DATA),
    .O_REC_VALID(O_REC_VALID), .O_PLAY_START(O_PLAY_START),
    .O_PLAY_VOLUME(O_PLAY_VOLUME), .O_CLEAR_TO_SEND_N(O_CLEAR_TO_SEND_N));

// file: asf_host_model.sv
// Host controller model: issues parsed commands, collects transmit bytes.
// Assumes the command handshake of asf_ctrl on one shared clock.
`timescale 1ns/1ps
module asf_host_model
(
    input  wire logic        i_clk,
    input  wire logic        i_ready,
    input  wire logic        i_tx_valid,
    input  wire logic [7:0]  i_tx_data,
    output logic             o_valid,
    output logic [2:0]       o_op,
    output logic [15:0]      o_arg
);
    logic [7:0] rx_q[$];
    time        rx_t[$];
    initial
    begin
        o_valid = 1'b0;
        o_op    = 3'h0;
        o_arg   = 16'h0000;
    end
    always @(negedge i_clk)
    begin
        if (i_tx_valid === 1'b1)
        begin
            rx_q.push_back(i_tx_data);
            rx_t.push_back($time);
        end
    end
    task automatic issue(input logic [2:0] op, input logic [15:0] arg);
        @(posedge i_clk);
        #1;
        o_valid = 1'b1;
        o_op    = op;
        // Control writes drop reserved bit 2 before sending
        o_arg   = (op == 3'h0) ? (arg & 16'hFFFB) : arg;
        while (i_ready !== 1'b1)
        begin
            @(posedge i_clk);
            #1;
        end
        @(posedge i_clk);
        #1;
        o_valid = 1'b0;
        o_op    = ~op;
        o_arg   = ~o_arg;
    endtask : issue
endmodule : asf_host_model

// file: tb_top.sv
// Self-checking bench for asf_ctrl with a host model on the command port.
// Assumes a short baud divider so one sample takes twenty clocks.
`timescale 1ns/1ps
module tb_top;
    logic        clk;
    logic        arst_n;
    logic        cmd_valid;
    logic [2:0]  cmd_op;
    logic [15:0] cmd_arg;
    logic        ready;
    logic        trig;
    logic        rec;
    logic [7:0]  adc;
    logic [2:0]  src;
    logic [7:0]  ctrl;
    logic        tx_valid;
    logic [7:0]  tx_data;
    logic        rec_valid;
    logic        play;
    logic [3:0]  play_idx;
    logic [3:0]  vol;
    logic        cts_n;
    logic [4:0]  count;
    logic [3:0]  last_play;
    int          mismatches;
    int          total_checks;
    int          cycles;
    int          rec_count;

    // Converter result reveals which input was sampled
    assign adc = 8'h30 + {5'h00, src};

    asf_ctrl #(.CLKS_PER_BAUD(2)) dut (.I_CLOCK(clk), .I_ARST_N(arst_n),
        .I_CMD_VALID(cmd_valid), .I_CMD_OP(cmd_op), .I_CMD_ARG(cmd_arg),
        .O_CMD_READY(ready), .I_EXT_TRIGGER(trig), .I_RECORD_ACTIVE(rec),
        .I_ADC_RESULT(adc), .O_ADC_SOURCE(src), .O_GAIN_ROUTE(), .O_CTRL_VALUE(ctrl),
        .O_TX_VALID(tx_valid), .O_TX_DATA(tx_data), .O_REC_VALID(rec_valid),
        .O_REC_DATA(), .O_PLAY_START(play), .O_PLAY_INDEX(play_idx),
        .O_PLAY_VOLUME(vol), .O_CLEAR_TO_SEND_N(cts_n), .O_FILE_COUNT(count));

    asf_host_model host (.i_clk(clk), .i_ready(ready), .i_tx_valid(tx_valid),
        .i_tx_data(tx_data), .o_valid(cmd_valid), .o_op(cmd_op), .o_arg(cmd_arg));

    always #5 clk = ~clk;

    always @(negedge clk)
    begin
        if (rec_valid === 1'b1)
            rec_count++;
        if (play === 1'b1)
            last_play = play_idx;
    end

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            mismatches++;
            test_done();
        end
    end

    task automatic test_done;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : test_done

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : chk

    task automatic expect_tx(input logic [7:0] exp);
        int n;
        n = 0;
        while (host.rx_q.size() == 0 && n < 400)
        begin
            @(posedge clk);
            n++;
        end
        if (host.rx_q.size() == 0)
            chk(32'hFFFF_FFFF, {24'h0, exp});
        else
            chk({24'h0, host.rx_q.pop_front()}, {24'h0, exp});
    endtask : expect_tx

    task automatic idle(input int n);
        repeat (n) @(posedge clk);
    endtask : idle

    task automatic flush;
        host.rx_q.delete();
        host.rx_t.delete();
    endtask : flush

    initial
    begin
        clk = 1'b0;
        arst_n = 1'b0;
        trig = 1'b1;
        rec = 1'b0;
        idle(2);
        #1;
        arst_n = 1'b1;
        chk(ctrl, 8'h80);
        chk(vol, 4'h5);
        host.issue(3'h0, 16'h00C3);
        idle(30);
        chk(ctrl, 8'hC3);
        chk(src, 3'h4);
        chk(host.rx_q.size(), 0);
        host.issue(3'h0, 16'h0006);
        expect_tx(8'h32);
        idle(30);
        chk(ctrl, 8'h82);
        chk(host.rx_q.size(), 0);
        host.issue(3'h0, 16'h000A);
        expect_tx(8'h30);
        expect_tx(8'h31);
        expect_tx(8'h32);
        idle(40);
        chk(ctrl, 8'h8A);
        host.issue(3'h0, 16'h0040);
        expect_tx(8'h34);
        flush();
        host.issue(3'h0, 16'h0019);
        idle(100);
        chk(host.rx_t[1] - host.rx_t[0], 200);
        expect_tx(8'h30);
        expect_tx(8'h31);
        expect_tx(8'h30);
        host.issue(3'h0, 16'h0009);
        idle(4);
        flush();
        idle(40);
        chk(host.rx_q.size(), 0);
        chk(ctrl, 8'h89);
        host.issue(3'h0, 16'h0011);
        expect_tx(8'h31);
        expect_tx(8'h31);
        host.issue(3'h0, 16'h0091);
        flush();
        idle(40);
        chk(host.rx_q.size(), 0);
        host.issue(3'h0, 16'h0022);
        idle(50);
        chk(host.rx_q.size(), 0);
        #1;
        trig = 1'b0;
        expect_tx(8'h32);
        #1;
        trig = 1'b1;
        rec = 1'b1;
        host.issue(3'h0, 16'h0001);
        idle(400);
        chk(rec_count, 16);
        chk(host.rx_q.size(), 0);
        #1;
        rec = 1'b0;
        host.issue(3'h5, 16'd100);
        expect_tx(8'h00);
        host.issue(3'h5, 16'd200);
        expect_tx(8'h00);
        host.issue(3'h5, 16'd0);
        expect_tx(8'h00);
        chk(count, 5'h03);
        host.issue(3'h5, 16'd200);
        expect_tx(8'h0D);
        host.issue(3'h5, 16'hFFFF);
        expect_tx(8'h0D);
        host.issue(3'h1, 16'd1);
        expect_tx(8'h00);
        chk(last_play, 4'h1);
        host.issue(3'h3, 16'h0001);
        idle(4);
        flush();
        host.issue(3'h1, 16'd200);
        expect_tx(8'h00);
        chk(last_play, 4'h1);
        host.issue(3'h1, 16'd0);
        expect_tx(8'h0E);
        host.issue(3'h2, 16'd100);
        expect_tx(8'h04);
        expect_tx(8'h06);
        chk(count, 5'h02);
        host.issue(3'h1, 16'd200);
        expect_tx(8'h00);
        chk(last_play, 4'h0);
        host.issue(3'h2, 16'd999);
        expect_tx(8'h0E);
        host.issue(3'h7, 16'd0);
        expect_tx(8'h01);
        host.issue(3'h5, 16'd300);
        host.issue(3'h1, 16'd999);
        expect_tx(8'h00);
        expect_tx(8'h0E);
        host.issue(3'h4, 16'd12);
        idle(3);
        chk(vol, 4'h9);
        test_done();
    end
endmodule : tb_top
